// >>> verif/rcr_assertions.sv
`timescale 1ns/100ps
// ======
// Host side handshake checks
module rcr_chk #(parameter STARTUP_CYC = 20) (
  input wire clk, rst_n, clock_request, controller_on, other_fast_users, crystal_kick_start,
  input wire crystal_power, fast_xtal_stable, fast_clock_input_pin, slow_clock_input_pin, edge_dir_rise
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_kick_late: assert property ($rose(clock_request) && edge_dir_rise |-> ##[2:8] crystal_kick_start)
    else $error("late kick");
  a_kick_once: assert property (crystal_kick_start |=> !crystal_kick_start) else $error("long kick");
  a_kick_dir: assert property (crystal_kick_start |=> !edge_dir_rise) else $error("no flip");
  a_kick_pwr: assert property (crystal_kick_start |-> crystal_power) else $error("no power");
  a_stable_wait: assert property ($rose(fast_xtal_stable) |-> $past(crystal_power, STARTUP_CYC))
    else $error("early stable");
  a_pin_gate: assert property (fast_clock_input_pin |-> $past(fast_xtal_stable)) else $error("ungated");
  a_pwr_drop: assert property ($fell(fast_xtal_stable) |-> crystal_power == other_fast_users)
    else $error("bad power");
  a_slow_off: assert property (!controller_on [*4] |=> !slow_clock_input_pin) else $error("slow on");
  c_kick: cover property (crystal_kick_start);
  c_ready: cover property ($rose(fast_xtal_stable));
  c_drop: cover property ($fell(fast_xtal_stable));
endmodule // rcr_chk

// >>> verif/rcr_clock_request_bench.sv
`timescale 1ns/100ps
// ======
// Handshake scenarios
module rcr_clock_request_bench;
  reg clk = 1'b0, rst_n = 1'b0, controller_on = 1'b0, other_fast_users = 1'b0, wake = 1'b0;
  reg fast_xtal_clk = 1'b0, slow_xtal_clk = 1'b0;
  wire clock_request, on_fast, lost, crystal_kick_start, crystal_power, fast_xtal_stable;
  wire fast_clock_input_pin, slow_clock_input_pin, edge_dir_rise, timing_error;
  wire [5:0] mon = {slow_clock_input_pin, fast_clock_input_pin, !fast_xtal_stable, on_fast, fast_xtal_stable,
    crystal_kick_start};
  integer bad_count = 0, n_tests = 0, t;
  rcr_clock_request #(.STARTUP_CYC(20), .SWITCH_CYC(40)) uut (.clk, .rst_n, .clock_request, .controller_on,
    .fast_xtal_clk, .slow_xtal_clk, .other_fast_users, .crystal_kick_start, .crystal_power, .fast_xtal_stable,
    .fast_clock_input_pin, .slow_clock_input_pin, .edge_dir_rise, .timing_error);
  rcr_radio_model ctl (.clk, .wake, .fast_xtal_stable, .clock_request, .on_fast, .lost);
  initial begin
    forever #50 clk = ~clk;
  end
  always #150 fast_xtal_clk = ~fast_xtal_clk;
  always #400 slow_xtal_clk = ~slow_xtal_clk;
  task chk(input logic got, input logic exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: got %b want %b", $time, got, exp);
    end
  endtask
  // Waits a bounded number of cycles for one monitored flag
  task wait_bit(input integer b, input integer lim);
    t = 0;
    while (mon[b] !== 1'b1 && t < lim) begin
      @(negedge clk);
      t = t + 1;
    end
    chk(mon[b], 1'b1);
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task t_off;
    repeat (12) @(negedge clk);
    chk(slow_clock_input_pin, 1'b0);
    chk(edge_dir_rise, 1'b1);
    $display("off done");
  endtask
  task t_wake;
    wake <= 1'b1;
    wait_bit(0, 8);
    @(negedge clk);
    chk(crystal_kick_start, 1'b0);
    chk(edge_dir_rise, 1'b0);
    wait_bit(1, 30);
    chk(t >= 19, 1'b1);
    wait_bit(2, 45);
    chk(lost, 1'b0);
    wait_bit(4, 4);
    $display("wake done");
  endtask
  task t_sleep(input logic o);
    other_fast_users = o;
    wake <= 1'b0;
    wait_bit(3, 12);
    @(negedge clk);
    chk(crystal_power, o);
    chk(edge_dir_rise, 1'b1);
    chk(fast_clock_input_pin, 1'b0);
    wait_bit(5, 9);
    $display("sleep done");
  endtask
  task t_abort;
    wake <= 1'b1;
    wait_bit(0, 8);
    repeat (5) @(negedge clk);
    wake <= 1'b0;
    repeat (30) @(negedge clk);
    chk(crystal_power, 1'b0);
    chk(fast_xtal_stable, 1'b0);
    chk(edge_dir_rise, 1'b1);
    $display("abort done");
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_off;
    controller_on = 1'b1;
    t_wake;
    t_sleep(1'b1);
    t_wake;
    t_sleep(1'b0);
    t_abort;
    chk(timing_error, 1'b0);
    report_and_stop;
  end
  initial begin
    #100000;
    bad_count = bad_count + 1;
    report_and_stop;
  end
endmodule // rcr_clock_request_bench
bind rcr_clock_request rcr_chk #(.STARTUP_CYC(STARTUP_CYC)) chk_i (.clk, .rst_n, .clock_request, .controller_on,
  .other_fast_users, .crystal_kick_start, .crystal_power, .fast_xtal_stable, .fast_clock_input_pin,
  .slow_clock_input_pin, .edge_dir_rise);

// >>> verif/rcr_radio_model.sv
`timescale 1ns/100ps
// ======
// Radio controller asking for the fast clock
module rcr_radio_model #(parameter EXT_W = 40, TMR_W = 40) (
  input  wire clk, wake, fast_xtal_stable,
  output reg  clock_request = 1'b0, on_fast = 1'b0, lost = 1'b0
);
  localparam W = EXT_W > TMR_W ? EXT_W : TMR_W;
  integer n = 0;
  always @(negedge clk) begin
    n <= wake ? n + 1 : 0;
    if (wake)
      clock_request <= 1'b1;
    if (wake && n == W) begin
      on_fast <= 1'b1;
      lost <= lost | !fast_xtal_stable;
    end
    if (!wake)
      on_fast <= 1'b0;
    if (!wake && !on_fast)
      clock_request <= 1'b0;
  end
endmodule // rcr_radio_model

// >>> verilog/rcr_clock_request.v
`timescale 1ns/100ps
`include "rcr_consts.vh"
// Notes on behaviour
// - Host starts the fast crystal when it sees the request rise.
// - Crystal start-up must be strictly shorter than the switch delay.
// - Host waits at least 750 us before treating the crystal as stable.
// - Host drives fast and slow clocks single-ended onto controller pins.
// - Slow clock runs continuously once controller is on, ignoring request.
// - Host gates fast clock output when request drops; may power down crystal.
// - Crystal powers down by default unless other host users need it.
// - Host answers within switch delay minus start-up delay of the request.
// - Handler samples request, kicks or disables crystal, flips edge direction.
// - Longer switch delay tolerates slow handlers but costs wake power.
module rcr_clock_request #(
  parameter STARTUP_CYC = `RCR_XTAL_STARTUP_CYC,
  parameter SWITCH_CYC  = `RCR_SWITCH_DELAY_CYC
) (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Controller handshake
  input  wire clock_request,
  input  wire controller_on,
  // Crystal sources
  input  wire fast_xtal_clk,
  input  wire slow_xtal_clk,
  input  wire other_fast_users,
  // Crystal control and pins
  output reg  crystal_kick_start,
  output reg  crystal_power,
  output reg  fast_xtal_stable,
  output reg  fast_clock_input_pin,
  output reg  slow_clock_input_pin,
  output reg  edge_dir_rise,
  output reg  timing_error
);
  // ==========================================
  // Request and controller-on synchronisers
  wire req_lvl;
  wire req_rise;
  wire req_fall;
  wire on_lvl;

  rcr_sync u_req (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (clock_request),
    .dout  (req_lvl),
    .rise  (req_rise),
    .fall  (req_fall)
  );

  rcr_sync u_on (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (controller_on),
    .dout  (on_lvl),
    .rise  (),
    .fall  ()
  );

  // ==========================================
  // Handler: edge matching current direction
  // The delayed level still shows the old value in the cycle an edge is
  // flagged, so the handler samples the level that goes with the edge
  wire req_now = req_rise | (req_lvl & ~req_fall);
  wire hit     = edge_dir_rise ? req_rise : req_fall;

  // ==========================================
  // Decoding helpers
  // Crystal held powered on behalf of the controller
  function xtal_in_use;
    input [1:0] st;
    begin
      xtal_in_use = (st == `RCR_ST_START) || (st == `RCR_ST_RUN);
    end
  endfunction

  // Start-up wait over, crystal usable by the controller
  function xtal_ready;
    input [1:0] st;
    begin
      xtal_ready = (st == `RCR_ST_RUN);
    end
  endfunction

  // Request edge that must power the crystal up
  function kick_due;
    input [1:0] st;
    input       edge_hit;
    input       level;
    begin
      kick_due = (st == `RCR_ST_OFF) && edge_hit && level;
    end
  endfunction

  // Request edge that must release the crystal
  function drop_due;
    input [1:0] st;
    input       edge_hit;
    input       level;
    begin
      drop_due = xtal_in_use(st) && edge_hit && !level;
    end
  endfunction

  // ==========================================
  // Crystal state machine
  // Off: crystal released; start: start-up wait running; run: crystal
  // usable and fed to the controller while its request stands
  reg [1:0]             state;
  reg [1:0]             next_state;
  reg [`RCR_CNT_W-1:0]  cnt;
  reg [`RCR_CNT_W-1:0]  next_cnt;
  reg [`RCR_CNT_W-1:0]  req_cnt;
  reg [`RCR_CNT_W-1:0]  next_req_cnt;
  reg                   next_kick;
  reg                   next_dir;
  reg                   next_stable;
  reg                   next_power;
  reg                   next_error;

  // Last count of the start-up wait and the switch delay in cycles
  wire [`RCR_CNT_W-1:0] startup_last = STARTUP_CYC[`RCR_CNT_W-1:0] - 16'h0001;
  wire [`RCR_CNT_W-1:0] switch_limit = SWITCH_CYC[`RCR_CNT_W-1:0];

  always @* begin
    next_state = state;
    case (state)
      `RCR_ST_OFF: begin
        if (kick_due(state, hit, req_now))
          next_state = `RCR_ST_START;
      end
      `RCR_ST_START: begin
        // A drop during start-up abandons the wait
        if (drop_due(state, hit, req_now))
          next_state = `RCR_ST_OFF;
        else if (cnt == startup_last)
          next_state = `RCR_ST_RUN;
      end
      `RCR_ST_RUN: begin
        if (drop_due(state, hit, req_now))
          next_state = `RCR_ST_OFF;
      end
      default: next_state = `RCR_ST_OFF;
    endcase
  end

  // ==========================================
  // Next value of the start-up wait counter
  // Runs only while the crystal is starting
  always @* begin
    if (state == `RCR_ST_START && next_state == `RCR_ST_START)
      next_cnt = cnt + 16'h0001;
    else
      next_cnt = 16'h0000;
  end

  // ==========================================
  // Next value of the request-high counter
  // Saturates instead of wrapping back to zero
  always @* begin
    if (!req_lvl)
      next_req_cnt = 16'h0000;
    else if (req_cnt != 16'hFFFF)
      next_req_cnt = req_cnt + 16'h0001;
    else
      next_req_cnt = req_cnt;
  end

  // ==========================================
  // Next values of the handler outputs
  // Each handler run flips the edge direction
  always @* begin
    next_dir  = hit ? ~edge_dir_rise : edge_dir_rise;
    next_kick = kick_due(state, hit, req_now);
  end

  // ==========================================
  // Next values of the crystal flags
  always @* begin
    next_stable = xtal_ready(next_state);
    // Crystal keeps running while other users need it
    next_power  = xtal_in_use(next_state) || other_fast_users;
    // Switch delay reached before the crystal was usable
    next_error  = timing_error ||
                  (req_lvl && req_cnt == switch_limit && !xtal_ready(state));
  end

  // ==========================================
  // State register
  always @(posedge clk) begin
    if (!rst_n)
      state <= `RCR_ST_OFF;
    else
      state <= next_state;
  end

  // ==========================================
  // Start-up wait counter
  always @(posedge clk) begin
    if (!rst_n)
      cnt <= 16'h0000;
    else
      cnt <= next_cnt;
  end

  // ==========================================
  // Request-high time counter
  // Measures how long the controller has held its request
  always @(posedge clk) begin
    if (!rst_n)
      req_cnt <= 16'h0000;
    else
      req_cnt <= next_req_cnt;
  end

  // ==========================================
  // Handler edge direction, rising edge first
  always @(posedge clk) begin
    if (!rst_n)
      edge_dir_rise <= 1'b1;
    else
      edge_dir_rise <= next_dir;
  end

  // ==========================================
  // Crystal power-up kick, one cycle wide
  always @(posedge clk) begin
    if (!rst_n)
      crystal_kick_start <= 1'b0;
    else
      crystal_kick_start <= next_kick;
  end

  // ==========================================
  // Crystal power
  // Powering down follows the drop unless another host user holds it on
  always @(posedge clk) begin
    if (!rst_n)
      crystal_power <= 1'b0;
    else
      crystal_power <= next_power;
  end

  // ==========================================
  // Crystal stable flag
  always @(posedge clk) begin
    if (!rst_n)
      fast_xtal_stable <= 1'b0;
    else
      fast_xtal_stable <= next_stable;
  end

  // ==========================================
  // Timing error, sticky until reset
  // Flags a controller that would switch onto a crystal still starting
  always @(posedge clk) begin
    if (!rst_n)
      timing_error <= 1'b0;
    else
      timing_error <= next_error;
  end

  // ==========================================
  // Crystal clock samplers
  // Index 0 carries the fast crystal, index 1 the slow one
  wire [1:0] xtal_raw = {slow_xtal_clk, fast_xtal_clk};
  wire [1:0] xtal_smp;
  genvar     gi;

  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_xtal
      reg [1:0] pipe;

      always @(posedge clk) begin
        if (!rst_n)
          pipe <= 2'h0;
        else
          pipe <= {pipe[0], xtal_raw[gi]};
      end

      assign xtal_smp[gi] = pipe[1];
    end
  endgenerate

  // ==========================================
  // Fast clock pin
  // Needs a stable crystal and a request that still stands
  always @(posedge clk) begin
    if (!rst_n)
      fast_clock_input_pin <= 1'b0;
    else
      fast_clock_input_pin <= xtal_smp[0] & fast_xtal_stable & req_lvl;
  end

  // ==========================================
  // Slow clock pin
  // Runs whenever the controller is on, whatever the request does
  always @(posedge clk) begin
    if (!rst_n)
      slow_clock_input_pin <= 1'b0;
    else
      slow_clock_input_pin <= xtal_smp[1] & on_lvl;
  end
endmodule // rcr_clock_request

// >>> verilog/rcr_consts.vh
`ifndef RCR_CONSTS_VH
`define RCR_CONSTS_VH

// Clock rate of the host logic in kHz
`define RCR_CLK_KHZ              10000
// Least crystal start-up time in microseconds
`define RCR_XTAL_STARTUP_US      750
// Default controller switch delay in microseconds
`define RCR_SWITCH_DELAY_US      1000
// Start-up wait in cycles, rounded up
`define RCR_XTAL_STARTUP_CYC     ((`RCR_XTAL_STARTUP_US * `RCR_CLK_KHZ + 999) / 1000)
// Switch delay in cycles, rounded down
`define RCR_SWITCH_DELAY_CYC     ((`RCR_SWITCH_DELAY_US * `RCR_CLK_KHZ) / 1000)
// Counter width for the start-up wait
`define RCR_CNT_W                16
// Crystal control states
`define RCR_ST_OFF               2'h0
`define RCR_ST_START             2'h1
`define RCR_ST_RUN               2'h2

`endif

// >>> verilog/rcr_sync.v
`timescale 1ns/100ps
// ==========================================
// Two-stage synchroniser plus a delay register for the level and edge outputs
module rcr_sync (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  // Asynchronous input
  input  wire din,
  // Synchronised level and edges
  output reg  dout,
  output wire rise,
  output wire fall
);
  reg meta;
  reg sync;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      sync <= meta;
      dout <= sync;
    end
  end

  assign rise = sync & ~dout;
  assign fall = ~sync & dout;
endmodule // rcr_sync
